//--- hdl/pcg_pkg.sv
// Constants, register map and state types for the peripheral clock gating block.
// Assumes a single 100 MHz bus clock and a 32-bit AXI4-Lite register port.
package pcg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] GATE_CTRL_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] GATE_SET_OFF = 8'h40;
  localparam logic [ADDR_W-1:0] GATE_CLR_OFF = 8'h44;
  localparam logic [ADDR_W-1:0] GATE_STAT_OFF = 8'h48;
  // ==========================================================
  // Field positions of the gate control register
  localparam int COMP_B_BIT = 31;
  localparam int COMP_A_BIT = 30;
  localparam int CONV_BIT = 29;
  localparam int EXT_IRQ_BIT = 27;
  localparam int KEYPAD_B_BIT = 25;
  localparam int KEYPAD_A_BIT = 24;
  localparam int SERIAL_C_BIT = 22;
  localparam int SERIAL_B_BIT = 21;
  localparam int SERIAL_A_BIT = 20;
  localparam int SYNC_B_BIT = 19;
  localparam int SYNC_A_BIT = 18;
  localparam int TWO_WIRE_B_BIT = 17;
  localparam int TWO_WIRE_A_BIT = 16;
  localparam int CAN_BIT = 15;
  localparam int DEBUG_BIT = 13;
  localparam int FLASH_BIT = 12;
  // Implemented gate bits; every other position is reserved and reads zero
  localparam logic [DATA_W-1:0] GATE_MASK = 32'hEB7F_B000;
  // Flash and debugger clocked out of reset so the system can run
  localparam logic [DATA_W-1:0] GATE_CTRL_RST = 32'h0000_3000;
  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ==========================================================
  // State types
  typedef struct packed {
    logic [ADDR_W-1:0] awAddr;
    logic awHeld;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic wHeld;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
    logic [DATA_W-1:0] gateCtrl;
  } pcg_state_t;
  localparam pcg_state_t STATE_RST = '{gateCtrl: GATE_CTRL_RST, default: '0};
  typedef struct packed {
    logic enLow;
  } pcg_cell_t;
endpackage

//--- hdl/pcg_gate_if.sv
// Carrier between the register logic and the clock gate bank.
// Assumes both sides sit on the same bus clock.
`timescale 1ns/1ns
`default_nettype none
interface pcg_gate_if;
  logic [31:0] gateEn;
  logic [31:0] gateOn;
  logic [31:0] gatedClk;
  modport ctrl (output gateEn, input gateOn, input gatedClk);
  modport bank (input gateEn, output gateOn, output gatedClk);
endinterface
`default_nettype wire

//--- hdl/pcg_gate_cell.sv
// One glitch-free clock gate: enable retimed on the falling edge, then ANDed.
// Assumes en comes from logic on the rising edge of the same clock.
`timescale 1ns/1ns
`default_nettype none
module pcg_gate_cell (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  output logic gatedClk,
  output logic enApplied
);
  pcg_pkg::pcg_cell_t cell_reg;
  pcg_pkg::pcg_cell_t cell_next;

  always_comb begin
    cell_next = cell_reg;
    cell_next.enLow = en;
  end

  // Enable only changes while clk is low, so no pulse is ever cut short
  always_ff @(negedge clk) begin
    if (!nrst) begin
      cell_reg <= '0;
    end else begin
      cell_reg <= cell_next;
    end
  end

  assign gatedClk = clk & cell_reg.enLow;
  assign enApplied = cell_reg.enLow;
endmodule // pcg_gate_cell
`default_nettype wire

//--- hdl/pcg_gate_bank.sv
// Bank of clock gates, one per implemented enable bit.
// Assumes the mask marks which bit positions drive a peripheral.
`timescale 1ns/1ns
`default_nettype none
module pcg_gate_bank #(
  parameter logic [31:0] MASK = pcg_pkg::GATE_MASK
) (
  input wire logic clk,
  input wire logic nrst,
  pcg_gate_if.bank gate
);
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_gate
      if (MASK[i]) begin : g_on
        pcg_gate_cell u_cell (
          .clk(clk),
          .nrst(nrst),
          .en(gate.gateEn[i]),
          .gatedClk(gate.gatedClk[i]),
          .enApplied(gate.gateOn[i])
        );
      end else begin : g_off
        // Reserved positions carry no clock at all
        assign gate.gatedClk[i] = 1'b0;
        assign gate.gateOn[i] = 1'b0;
      end
    end
  endgenerate
endmodule // pcg_gate_bank
`default_nettype wire

//--- hdl/pcg_top.sv
// Peripheral clock gating: AXI4-Lite register port and gated bus clocks.
// Assumes a single bus clock; gated clocks feed peripherals on that clock.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - bit 31 gates second comparator clock
// - bit 30 gates first comparator clock
// - bit 29 gates converter clock
// - reserved bits read zero, ignore writes
// - bit 27 gates external interrupt clock
// - bit 25 gates second keypad clock
// - bit 24 gates first keypad clock
// - bit 22 gates third serial port
// - bit 21 gates second serial port
// - bit 20 gates first serial port
// - bit 19 gates second synchronous serial
// - bit 18 gates first synchronous serial
// - bit 17 gates second two-wire bus
// - bit 16 gates first two-wire bus
// - bit 15 gates network controller clock
// - bit 13 gates debugger clock
// - bit 12 controls flash clock gate
// - flash clock on when set, off cleared
module pcg_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [pcg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic comparatorBClk,
  output logic comparatorAClk,
  output logic converterClk,
  output logic extIrqClk,
  output logic keypadBClk,
  output logic keypadAClk,
  output logic serialCClk,
  output logic serialBClk,
  output logic serialAClk,
  output logic syncSerialBClk,
  output logic syncSerialAClk,
  output logic twoWireBClk,
  output logic twoWireAClk,
  output logic canClk,
  output logic debugClk,
  output logic flashClk
);
  // ==========================================================
  // State
  pcg_pkg::pcg_state_t st_reg;
  pcg_pkg::pcg_state_t st_next;

  logic awFire;
  logic wFire;
  logic arFire;
  logic haveAw;
  logic haveW;
  logic [pcg_pkg::ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [31:0] laneMask;
  logic [31:0] merged;

  pcg_gate_if gate ();

  // ==========================================================
  // Bus handshakes
  // One write and one read in flight; a channel reopens once its answer is taken
  assign s_axi_awready = !st_reg.awHeld && !st_reg.bValid;
  assign s_axi_wready = !st_reg.wHeld && !st_reg.bValid;
  assign s_axi_arready = !st_reg.rValid;
  assign awFire = s_axi_awvalid && s_axi_awready;
  assign wFire = s_axi_wvalid && s_axi_wready;
  assign arFire = s_axi_arvalid && s_axi_arready;

  // Address and data may arrive in either order; the held copy wins
  assign haveAw = st_reg.awHeld || awFire;
  assign haveW = st_reg.wHeld || wFire;
  assign wrAddr = st_reg.awHeld ? st_reg.awAddr : s_axi_awaddr;
  assign wrData = st_reg.wHeld ? st_reg.wData : s_axi_wdata;
  assign wrStrb = st_reg.wHeld ? st_reg.wStrb : s_axi_wstrb;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign laneMask[8*lane +: 8] = {8{wrStrb[lane]}};
    end
  endgenerate

  // Lanes without a strobe keep their old contents
  assign merged = (wrData & laneMask) | (st_reg.gateCtrl & ~laneMask);

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'b0;
    end
    if (awFire) begin
      st_next.awAddr = s_axi_awaddr;
      st_next.awHeld = 1'b1;
    end
    if (wFire) begin
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
      st_next.wHeld = 1'b1;
    end
    // Commit as soon as both halves are present, in the cycle the last arrives
    if (haveAw && haveW) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = pcg_pkg::RESP_OKAY;
      unique case (wrAddr[pcg_pkg::ADDR_W-1:2])
        pcg_pkg::GATE_CTRL_OFF[pcg_pkg::ADDR_W-1:2]: begin
          st_next.gateCtrl = merged & pcg_pkg::GATE_MASK;
        end
        // Set and clear aliases spare software a read-modify-write race
        pcg_pkg::GATE_SET_OFF[pcg_pkg::ADDR_W-1:2]: begin
          st_next.gateCtrl = st_reg.gateCtrl | (wrData & laneMask & pcg_pkg::GATE_MASK);
        end
        pcg_pkg::GATE_CLR_OFF[pcg_pkg::ADDR_W-1:2]: begin
          st_next.gateCtrl = st_reg.gateCtrl & ~(wrData & laneMask & pcg_pkg::GATE_MASK);
        end
        pcg_pkg::GATE_STAT_OFF[pcg_pkg::ADDR_W-1:2]: begin
          st_next.bResp = pcg_pkg::RESP_SLVERR;
        end
        default: begin
          st_next.bResp = pcg_pkg::RESP_DECERR;
        end
      endcase
    end
    if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'b0;
    end
    if (arFire) begin
      st_next.rValid = 1'b1;
      st_next.rResp = pcg_pkg::RESP_OKAY;
      unique case (s_axi_araddr[pcg_pkg::ADDR_W-1:2])
        pcg_pkg::GATE_CTRL_OFF[pcg_pkg::ADDR_W-1:2],
        pcg_pkg::GATE_SET_OFF[pcg_pkg::ADDR_W-1:2],
        pcg_pkg::GATE_CLR_OFF[pcg_pkg::ADDR_W-1:2]: begin
          st_next.rData = st_reg.gateCtrl & pcg_pkg::GATE_MASK;
        end
        // Shows the enables the gates have actually taken up
        pcg_pkg::GATE_STAT_OFF[pcg_pkg::ADDR_W-1:2]: begin
          st_next.rData = gate.gateOn & pcg_pkg::GATE_MASK;
        end
        default: begin
          st_next.rData = 32'h0000_0000;
          st_next.rResp = pcg_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= pcg_pkg::STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Answers
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_bresp = st_reg.bResp;
  assign s_axi_rvalid = st_reg.rValid;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = st_reg.rResp;

  // ==========================================================
  // Clock gates
  assign gate.gateEn = st_reg.gateCtrl;

  pcg_gate_bank #(
    .MASK(pcg_pkg::GATE_MASK)
  ) u_bank (
    .clk(clk),
    .nrst(nrst),
    .gate(gate.bank)
  );

  assign comparatorBClk = gate.gatedClk[pcg_pkg::COMP_B_BIT];
  assign comparatorAClk = gate.gatedClk[pcg_pkg::COMP_A_BIT];
  assign converterClk = gate.gatedClk[pcg_pkg::CONV_BIT];
  assign extIrqClk = gate.gatedClk[pcg_pkg::EXT_IRQ_BIT];
  assign keypadBClk = gate.gatedClk[pcg_pkg::KEYPAD_B_BIT];
  assign keypadAClk = gate.gatedClk[pcg_pkg::KEYPAD_A_BIT];
  assign serialCClk = gate.gatedClk[pcg_pkg::SERIAL_C_BIT];
  assign serialBClk = gate.gatedClk[pcg_pkg::SERIAL_B_BIT];
  assign serialAClk = gate.gatedClk[pcg_pkg::SERIAL_A_BIT];
  assign syncSerialBClk = gate.gatedClk[pcg_pkg::SYNC_B_BIT];
  assign syncSerialAClk = gate.gatedClk[pcg_pkg::SYNC_A_BIT];
  assign twoWireBClk = gate.gatedClk[pcg_pkg::TWO_WIRE_B_BIT];
  assign twoWireAClk = gate.gatedClk[pcg_pkg::TWO_WIRE_A_BIT];
  assign canClk = gate.gatedClk[pcg_pkg::CAN_BIT];
  assign debugClk = gate.gatedClk[pcg_pkg::DEBUG_BIT];
  // Flash runs from reset so code fetch does not stall until software clears bit 12
  assign flashClk = gate.gatedClk[pcg_pkg::FLASH_BIT];
endmodule // pcg_top
`default_nettype wire

//--- sim/pcg_assertions.sv
// Port-level checks for the peripheral clock gating block.
// Assumes a bind to pcg_top on its one bus clock.
`timescale 1ns/1ns
`default_nettype none
module pcg_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flashClk,
  input wire logic debugClk,
  input wire logic canClk
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Register bus
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("no write response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // ==========================================
  // Gating
  rsvd_zero_a: assert property (s_axi_rvalid |->
    (s_axi_rdata & ~pcg_pkg::GATE_MASK) == 32'h0) else $error("reserved bits read nonzero");
  // Low phase just before each rising edge: a high here is a glitch
  no_glitch_a: assert property (!(flashClk || debugClk || canClk))
    else $error("gated clock high in low phase");
endmodule // pcg_assertions
`default_nettype wire

//--- sim/pcg_periph_model.sv
// Peripherals on the far side: each counts the pulses of its gated clock.
// Assumes clks[0] is bit 31's clock, then in descending bit order.
`timescale 1ns/1ns
`default_nettype none
module pcg_periph_model (
  input wire logic nrst,
  input wire logic [15:0] clks,
  output logic [15:0][15:0] cnt
);
  for (genvar i = 0; i < 16; i++) begin : g_unit
    always @(posedge clks[i] or negedge nrst) begin
      if (!nrst) cnt[i] <= 16'h0;
      else cnt[i] <= cnt[i] + 16'h1;
    end
  end
endmodule // pcg_periph_model
`default_nettype wire

//--- sim/peripheral_clock_gating_bench.sv
// Bench: AXI4-Lite master tasks driving pcg_top, pulse counts checked.
// Assumes 100 MHz clock and the register map of pcg_pkg.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module peripheral_clock_gating_bench;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wr, bv, arr, rv;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rd, d;
  logic [3:0] ws = 4'hF;
  logic [1:0] br, rr, r;
  logic [15:0] ck;
  logic [15:0][15:0] cnt, c0;
  int checks = 0, miscompares = 0;
  const int BITS[16] = '{31, 30, 29, 27, 25, 24, 22, 21, 20, 19, 18, 17, 16, 15, 13, 12};
  pcg_top DUT (.clk, .nrst, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .comparatorBClk(ck[0]), .comparatorAClk(ck[1]),
    .converterClk(ck[2]), .extIrqClk(ck[3]), .keypadBClk(ck[4]), .keypadAClk(ck[5]),
    .serialCClk(ck[6]), .serialBClk(ck[7]), .serialAClk(ck[8]), .syncSerialBClk(ck[9]),
    .syncSerialAClk(ck[10]), .twoWireBClk(ck[11]), .twoWireAClk(ck[12]), .canClk(ck[13]),
    .debugClk(ck[14]), .flashClk(ck[15]));
  pcg_periph_model partner (.nrst, .clks(ck), .cnt);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Samples at the falling edge, acts at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr; tw = wv && wr; tb = bv; r = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv && arr; tr = rv; d = rd; r = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask
  // One enable at a time: only its clock may run, a full pulse per cycle
  task automatic gateCheck(input int k);
    axw(pcg_pkg::GATE_CTRL_OFF, 32'h1 << BITS[k], 4'hF);
    @(negedge clk) c0 = cnt;
    repeat (8) @(negedge clk);
    for (int j = 0; j < 16; j++) `CHK(cnt[j] - c0[j], (j == k) ? 16'h8 : 16'h0)
  endtask
  task automatic doReset();
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    doReset();
    axr(pcg_pkg::GATE_CTRL_OFF); `CHK(d, pcg_pkg::GATE_CTRL_RST)
    axw(pcg_pkg::GATE_CTRL_OFF, 32'hFFFFFFFF, 4'hF); `CHK(r, pcg_pkg::RESP_OKAY)
    axr(pcg_pkg::GATE_CTRL_OFF); `CHK(d, pcg_pkg::GATE_MASK)
    gateCheck(0);
    gateCheck(1);
    gateCheck(2);
    gateCheck(3);
    gateCheck(4);
    gateCheck(5);
    gateCheck(6);
    gateCheck(7);
    gateCheck(8);
    gateCheck(9);
    gateCheck(10);
    gateCheck(11);
    gateCheck(12);
    gateCheck(13);
    gateCheck(14);
    gateCheck(15);
    axw(pcg_pkg::GATE_CTRL_OFF, 32'h0, 4'hF);
    axw(pcg_pkg::GATE_CTRL_OFF, 32'hFFFFFFFF, 4'h8);
    axr(pcg_pkg::GATE_CTRL_OFF); `CHK(d, 32'hEB000000)
    axw(pcg_pkg::GATE_SET_OFF, 32'h00008000, 4'hF);
    axw(pcg_pkg::GATE_CLR_OFF, 32'h80000000, 4'hF);
    axr(pcg_pkg::GATE_CTRL_OFF); `CHK(d, 32'h6B008000)
    axr(pcg_pkg::GATE_STAT_OFF); `CHK(d, 32'h6B008000)
    axw(pcg_pkg::GATE_STAT_OFF, 32'h0, 4'hF); `CHK(r, pcg_pkg::RESP_SLVERR)
    axw(8'h00, 32'hFFFFFFFF, 4'hF); `CHK(r, pcg_pkg::RESP_DECERR)
    axr(8'h00); `CHK({r, d}, {pcg_pkg::RESP_DECERR, 32'h0})
    doReset();
    axr(pcg_pkg::GATE_CTRL_OFF); `CHK(d, pcg_pkg::GATE_CTRL_RST)
    final_report();
  end
endmodule // peripheral_clock_gating_bench
bind pcg_top pcg_assertions chk (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .flashClk, .debugClk, .canClk);
`default_nettype wire
